// File: core/pfcd_core.sv
// The register offsets and register access over AHB-Lite were left to the implementer.
`include "pfcd_defs.svh"
// Operation
// - Substream valid flag 0 means no secondary tag, 1 means supplied and used.
// - Secure queue command uses select bit 0 non-secure, 1 secure tag.
// - Non-secure queue command with select bit 1 raises illegal command error.
// - Virtual address is command bits 63:12 with bits 11:0 zero.
// - Physical addresses carry 51:12, message target 51:2, rest zero.
// - Out-of-range parameter makes the command do nothing.
// - Stream tag out of range beyond width of its security state.
// - Secondary tag out of range beyond implemented secondary width.
// - Out-of-range prefetch never errors; bad address silently ignored.
// - Address out of range by stage 1 sign bits or stage 2 width.
// - Zero secondary width or context limit makes valid flag act as 0.
// - Prefetch to invalid config or faulting address fails silently.
// - Translation disabled: prefetch consumed but starts nothing.
// - Config prefetch fetches stream record, and context when tag valid.
// - Both stages with stage 2 updating set access flag on context fetch.
// - Address prefetch fetches records and translations for a span.
// - Targets are base plus n shifted by 12 plus stride, n below 2^size.
// - Early version ignores stride or raises illegal error when non-zero.
// - Number of translation operations per prefetch is capped.
// - Hardware updating marks stage 2 descriptors accessed for context fetch.
// - First error stops consumption, leaves index, reports code.
module pfcd_core (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire pfcd_pkg::pfcd_ahb_s ahb_in,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output pfcd_pkg::pfcd_req_s    pf_req,
  output logic                   cmd_error
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic tag_oor(input logic [31:0] v, input logic [5:0] w);
    tag_oor = (w < 6'h20) && ((v >> w) != 32'h0000_0000);
  endfunction : tag_oor

  function automatic logic addr_oor(input logic [63:0] a, input logic [31:0] c);
    logic [63:0] hi;
    logic [5:0]  vaw;
    logic [5:0]  intermediate_addr_width;
    hi  = 64'h0;
    vaw = c[13:8];
    intermediate_addr_width = c[19:14];
    addr_oor = 1'b0;
    if (c[`PFCD_C_S1] && vaw != 6'h00) begin
      hi = 64'($signed(a) >>> (vaw - 6'h01));
      if (hi != 64'h0 && hi != {64{1'b1}}) begin
        addr_oor = 1'b1;
      end
    end
    if (c[`PFCD_C_S2] && ((a >> intermediate_addr_width) != 64'h0)) begin
      addr_oor = 1'b1;
    end
  endfunction : addr_oor

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] cmd_r [4];
  logic [31:0] ctrl_r;
  logic [31:0] wid_r;
  logic        err_r;
  logic [1:0]  code_r;
  logic        ign_r;
  logic [31:0] cons_r;
  logic        q_sec_r;
  logic        go_r;
  logic        wr_ph_r;
  logic [7:0]  wa_r;
  pfcd_pkg::pfcd_state_e st_r;
  logic [63:0] addr_r;
  logic [63:0] step_r;
  logic [5:0]  cnt_r;
  logic [5:0]  lim_r;
  logic        fin_ok;
  logic        fin_err;
  logic        pf_ign;
  logic        en;

  wire logic a_ph = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
  wire logic wr_go = wr_ph_r && wa_r == `PFCD_A_SUBMIT;
  wire logic wr_st = wr_ph_r && wa_r == `PFCD_A_STATUS;

  // ****************************************
  // Bus slave
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ph_r   <= 1'b0;
      wa_r      <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_ph_r   <= a_ph && ahb_in.hwrite;
      wa_r      <= ahb_in.haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (a_ph && !ahb_in.hwrite) begin
      case (ahb_in.haddr[7:0])
        `PFCD_A_CMD0:   hrdata <= cmd_r[0];
        `PFCD_A_CMD1:   hrdata <= cmd_r[1];
        `PFCD_A_CMD2:   hrdata <= cmd_r[2];
        `PFCD_A_CMD3:   hrdata <= cmd_r[3];
        `PFCD_A_CTRL:   hrdata <= ctrl_r;
        `PFCD_A_WIDTHS: hrdata <= wid_r;
        `PFCD_A_STATUS: hrdata <= {27'h0, code_r, ign_r, err_r, st_r != pfcd_pkg::PFCD_IDLE};
        `PFCD_A_CONS:   hrdata <= cons_r;
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Command words are frozen while a command is in flight
  generate
    for (genvar i = 0; i < 4; i++) begin : g_cmd
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          cmd_r[i] <= 32'h0000_0000;
        end else if (wr_ph_r && wa_r == 8'(4 * i) && st_r == pfcd_pkg::PFCD_IDLE) begin
          cmd_r[i] <= ahb_in.hwdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= `PFCD_CTRL_RST;
      wid_r  <= `PFCD_WID_RST;
    end else if (wr_ph_r && wa_r == `PFCD_A_CTRL) begin
      ctrl_r <= ahb_in.hwdata;
    end else if (wr_ph_r && wa_r == `PFCD_A_WIDTHS) begin
      wid_r <= ahb_in.hwdata;
    end
  end

  // ****************************************
  // Submission and error state
  // ****************************************
  // A raised error blocks further commands until software clears it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      go_r    <= 1'b0;
      q_sec_r <= 1'b0;
    end else begin
      go_r <= wr_go && !err_r && st_r == pfcd_pkg::PFCD_IDLE;
      if (wr_go) begin
        q_sec_r <= ahb_in.hwdata[0] && ctrl_r[`PFCD_C_SECURE];
      end
    end
  end

  // Set wins over a clear written in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      err_r  <= 1'b0;
      code_r <= 2'h0;
      ign_r  <= 1'b0;
    end else begin
      if (fin_err) begin
        err_r  <= 1'b1;
        code_r <= `PFCD_ERR_ILL;
      end else if (wr_st && ahb_in.hwdata[`PFCD_S_ERR]) begin
        err_r  <= 1'b0;
        code_r <= 2'h0;
      end
      if (fin_ok) begin
        // Disabled translation counts as ignored, like a bad parameter
        ign_r <= go_r && (!en || pf_ign);
      end else if (wr_st && ahb_in.hwdata[`PFCD_S_IGN]) begin
        ign_r <= 1'b0;
      end
    end
  end

  // Consumed index stays on a failing command
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cons_r <= 32'h0000_0000;
    end else if (fin_ok) begin
      cons_r <= cons_r + 32'h0000_0001;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  wire logic [7:0]  op    = cmd_r[0][7:0];
  wire logic        ssv_f = cmd_r[0][`PFCD_B_SSV];
  wire logic        stream_security_select  = cmd_r[0][`PFCD_B_STREAM_SECURITY_SELECT];
  wire logic [19:0] ssid  = cmd_r[0][31:12];
  wire logic [31:0] sid   = cmd_r[1];
  wire logic [4:0]  size  = cmd_r[2][4:0];
  wire logic [4:0]  strd  = cmd_r[2][9:5];
  wire logic [63:0] va    = {cmd_r[3], cmd_r[2][31:12], 12'h000};
  wire logic        sec   = q_sec_r && stream_security_select;
  wire logic [5:0]  sidw  = sec ? wid_r[11:6] : wid_r[5:0];
  wire logic [4:0]  ssw   = wid_r[16:12];
  wire logic [4:0]  cdmax = wid_r[21:17];
  wire logic        ss_na = ssw == 5'h00 || cdmax == 5'h00;
  wire logic        substream_valid_flag   = ssv_f && !ss_na;
  wire logic        is_pf = op == `PFCD_OP_CFG || op == `PFCD_OP_ADDR;
  wire logic        v30   = ctrl_r[`PFCD_C_V30];
  wire logic        s_bad = !q_sec_r && stream_security_select;
  wire logic        d_bad = op == `PFCD_OP_ADDR && v30 && strd != 5'h00
                            && ctrl_r[`PFCD_C_STRICT];
  assign en = q_sec_r ? ctrl_r[`PFCD_C_S_EN] : ctrl_r[`PFCD_C_NS_EN];
  // Out-of-range tags or addresses quietly drop the whole command
  assign pf_ign = tag_oor(sid, sidw)
                             || (substream_valid_flag && tag_oor({12'h0, ssid}, {1'b0, ssw}))
                             || (op == `PFCD_OP_ADDR && addr_oor(va, ctrl_r));
  wire logic        af_on = ctrl_r[`PFCD_C_S1] && ctrl_r[`PFCD_C_S2]
                            && ctrl_r[`PFCD_C_HW_TABLE_UPDATE] && substream_valid_flag;

  assign fin_err = go_r && (!is_pf || s_bad || d_bad);
  assign fin_ok  = (go_r && !fin_err && (op == `PFCD_OP_CFG || !en || pf_ign))
                   || (st_r == pfcd_pkg::PFCD_WALK && cnt_r + 6'h01 >= lim_r);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= pfcd_pkg::PFCD_IDLE;
    end else begin
      case (st_r)
        pfcd_pkg::PFCD_IDLE: begin
          if (wr_go && !err_r) begin
            st_r <= pfcd_pkg::PFCD_DECODE;
          end
        end
        pfcd_pkg::PFCD_DECODE: begin
          if (fin_err || fin_ok) begin
            st_r <= pfcd_pkg::PFCD_IDLE;
          end else begin
            st_r <= pfcd_pkg::PFCD_WALK;
          end
        end
        pfcd_pkg::PFCD_WALK: begin
          if (fin_ok) begin
            st_r <= pfcd_pkg::PFCD_IDLE;
          end
        end
        default: st_r <= pfcd_pkg::PFCD_IDLE;
      endcase
    end
  end

  // Span is cut at a fixed number of lookups so one command cannot
  // hold the engine for up to 2^31 cycles
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_r <= 64'h0;
      step_r <= 64'h0;
      cnt_r  <= 6'h00;
      lim_r  <= 6'h01;
    end else if (go_r) begin
      addr_r <= va;
      step_r <= 64'h1 << (`PFCD_VA_LSB + (v30 ? 5'h00 : strd));
      cnt_r  <= 6'h00;
      lim_r  <= size >= `PFCD_MAX_LOG ? `PFCD_MAX_OPS : 6'(1 << size);
    end else if (st_r == pfcd_pkg::PFCD_WALK) begin
      addr_r <= addr_r + step_r;
      cnt_r  <= cnt_r + 6'h01;
    end
  end

  // ****************************************
  // Requests to the translation caches
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pf_req    <= '0;
      cmd_error <= 1'b0;
    end else begin
      cmd_error         <= err_r || fin_err;
      pf_req.cfg_valid  <= go_r && !fin_err && en && !pf_ign;
      pf_req.ctx_valid  <= go_r && !fin_err && en && !pf_ign && substream_valid_flag;
      pf_req.af_set     <= go_r && !fin_err && en && !pf_ign && af_on;
      pf_req.tr_valid   <= st_r == pfcd_pkg::PFCD_WALK;
      if (go_r) begin
        pf_req.secure <= sec;
        pf_req.sid    <= sid;
        pf_req.substream_valid_flag    <= substream_valid_flag;
        pf_req.ssid   <= substream_valid_flag ? ssid : 20'h0;
        pf_req.addr   <= va;
      end else if (st_r == pfcd_pkg::PFCD_WALK) begin
        pf_req.addr <= addr_r;
      end
    end
  end

endmodule : pfcd_core

// File: shared/pfcd_defs.svh
`ifndef PFCD_DEFS_SVH
`define PFCD_DEFS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define PFCD_A_CMD0    8'h00
`define PFCD_A_CMD1    8'h04
`define PFCD_A_CMD2    8'h08
`define PFCD_A_CMD3    8'h0c
`define PFCD_A_SUBMIT  8'h10
`define PFCD_A_CTRL    8'h14
`define PFCD_A_WIDTHS  8'h18
`define PFCD_A_STATUS  8'h1c
`define PFCD_A_CONS    8'h20
// ****************************************
// Command fields
// ****************************************
`define PFCD_OP_CFG    8'h01
`define PFCD_OP_ADDR   8'h02
`define PFCD_B_SSV     11
`define PFCD_B_STREAM_SECURITY_SELECT    10
`define PFCD_VA_LSB    12
// ****************************************
// CTRL bits
// ****************************************
`define PFCD_C_NS_EN   0
`define PFCD_C_S_EN    1
`define PFCD_C_SECURE  2
`define PFCD_C_S1      3
`define PFCD_C_S2      4
`define PFCD_C_HW_TABLE_UPDATE    5
`define PFCD_C_V30     6
`define PFCD_C_STRICT  7
`define PFCD_CTRL_RST  32'h0000_ffc0
// ****************************************
// Status and limits
// ****************************************
`define PFCD_S_BUSY    0
`define PFCD_S_ERR     1
`define PFCD_S_IGN     2
`define PFCD_ERR_ILL   2'h1
`define PFCD_WID_RST   32'h0000_0000
`define PFCD_MAX_LOG   5'h04
`define PFCD_MAX_OPS   6'h10
`endif

// File: shared/pfcd_pkg.sv
package pfcd_pkg;
  typedef struct packed {
    logic        cfg_valid;
    logic        ctx_valid;
    logic        tr_valid;
    logic        af_set;
    logic        secure;
    logic [31:0] sid;
    logic        substream_valid_flag;
    logic [19:0] ssid;
    logic [63:0] addr;
  } pfcd_req_s;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } pfcd_ahb_s;

  typedef enum logic [1:0] {
    PFCD_IDLE,
    PFCD_DECODE,
    PFCD_WALK
  } pfcd_state_e;
endpackage : pfcd_pkg

// File: tb/pfcd_core_asserts.sv
module pfcd_checker (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire pfcd_pkg::pfcd_ahb_s ahb_in,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire pfcd_pkg::pfcd_req_s pf_req,
  input wire logic                cmd_error
);
  timeunit 1ns;
  timeprecision 1ns;
  // **********
  // Span length
  // **********
  logic [4:0] run_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !pf_req.tr_valid) begin
      run_r <= 5'h00;
    end else begin
      run_r <= run_r + 5'h01;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_CTX_WITH_CFG:
    assert property (pf_req.ctx_valid |-> pf_req.cfg_valid && pf_req.substream_valid_flag) else $error("ctx without cfg");
  AST_AF_WITH_CTX:
    assert property (pf_req.af_set |-> pf_req.ctx_valid) else $error("af without ctx");
  AST_CFG_PULSE:
    assert property (pf_req.cfg_valid |=> !pf_req.cfg_valid) else $error("cfg not a pulse");
  AST_VA_ALIGN:
    assert property (pf_req.tr_valid |-> pf_req.addr[11:0] == 12'h000) else $error("addr low bits set");
  AST_WALK_START:
    assert property ($rose(pf_req.tr_valid) |-> $past(pf_req.cfg_valid)) else $error("walk without cfg");
  AST_SPAN_CAP:
    assert property (pf_req.tr_valid |-> run_r < 5'h10) else $error("span over cap");
  AST_EVEN_STEP:
    assert property (pf_req.tr_valid && $past(pf_req.tr_valid) && $past(pf_req.tr_valid, 2)
      |-> pf_req.addr - $past(pf_req.addr) == $past(pf_req.addr) - $past(pf_req.addr, 2)) else $error("uneven step");
  AST_ERR_QUIET:
    assert property (cmd_error && $past(cmd_error) |-> !pf_req.cfg_valid && !pf_req.tr_valid)
      else $error("request while in error");
  cover property (pf_req.af_set);
  cover property (pf_req.tr_valid [*8]);
  cover property ($rose(cmd_error));
endmodule : pfcd_checker

bind pfcd_core pfcd_checker u_pfcd_checker (.clk_sys(clk_sys), .rst_n(rst_n), .ahb_in(ahb_in),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pf_req(pf_req), .cmd_error(cmd_error));

// File: tb/pfcd_sw_model.sv
module pfcd_sw_model (
  input  wire logic          clk_sys,
  input  wire logic          hreadyout,
  input  wire logic [31:0]   hrdata,
  output pfcd_pkg::pfcd_ahb_s ahb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  pfcd_pkg::pfcd_ahb_s m = '0;
  always_comb begin
    ahb_o = m;
    ahb_o.hready = hreadyout;
  end
  // **********
  // Bus master
  // **********
  // A stuck slave ends the run instead of hanging it
  task automatic wt();
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (!hreadyout && i < 64);
    if (!hreadyout) begin
      prefetch_command_decode_test.bad_count++;
      prefetch_command_decode_test.test_done();
    end
  endtask : wt
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    m.hsel <= 1'b1;
    m.htrans <= 2'h2;
    m.hwrite <= w;
    m.hsize <= 3'h2;
    m.haddr <= {24'h000000, a};
    wt();
    m.hsel <= 1'b0;
    m.htrans <= 2'h0;
    m.hwdata <= d;
    wt();
    q = hrdata;
  endtask : xfer
endmodule : pfcd_sw_model

// File: tb/prefetch_command_decode_test.sv
`include "pfcd_defs.svh"
module prefetch_command_decode_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [31:0] ctl, wid, c0, c1, c2;
    logic        sub;
    int          tr;
    logic [4:0]  f;
  } pfcd_row_s;
  localparam logic [31:0] cc = 32'h0000_00c7;
  localparam logic [31:0] ww = 32'h0002_4108;
  logic                clk_sys = 1'b0;
  logic                rst_n = 1'b0;
  pfcd_pkg::pfcd_ahb_s ahb_in;
  pfcd_pkg::pfcd_req_s pf_req;
  logic [31:0]         hrdata, s, c0, c1;
  logic                hreadyout, hresp, cmd_error, sec;
  logic [63:0]         a0, a1;
  logic [52:0]         tg;
  int                  bad_count = 0, num_checks = 0, n_cfg, n_ctx, n_af, n_tr;
  // **********
  // Cases: f is {secure, af, ctx, ignored, error}
  // **********
  pfcd_row_s rows [15] = '{
    '{cc, ww, 32'h01, 32'h05, 32'h0, 1'b0, 0, 5'h00},
    '{cc, ww, 32'h3801, 32'h05, 32'h0, 1'b0, 0, 5'h04},
    '{cc, ww, 32'h02, 32'h05, 32'h1234_5002, 1'b0, 4, 5'h00},
    '{cc, ww, 32'h02, 32'h05, 32'h1234_5005, 1'b0, 16, 5'h00},
    '{cc, ww, 32'h401, 32'h05, 32'h0, 1'b0, 0, 5'h01},
    '{cc, ww, 32'h03, 32'h05, 32'h0, 1'b0, 0, 5'h01},
    '{cc, ww, 32'h01, 32'h100, 32'h0, 1'b0, 0, 5'h02},
    '{cc, ww, 32'h401, 32'h0f, 32'h0, 1'b1, 0, 5'h10},
    '{cc, ww, 32'h401, 32'h10, 32'h0, 1'b1, 0, 5'h02},
    '{cc, ww, 32'h01, 32'h10, 32'h0, 1'b1, 0, 5'h00},
    '{cc, ww, 32'h10801, 32'h05, 32'h0, 1'b0, 0, 5'h02},
    '{cc, ww, 32'h02, 32'h05, 32'h1000_0020, 1'b0, 0, 5'h01},
    '{32'h0000_00c6, ww, 32'h01, 32'h05, 32'h0, 1'b0, 0, 5'h02},
    '{cc, 32'h0002_0108, 32'h0801, 32'h05, 32'h0, 1'b0, 0, 5'h00},
    '{32'h0000_00ff, ww, 32'h3801, 32'h05, 32'h0, 1'b0, 0, 5'h0c}
  };
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  pfcd_core u_pfcd_core (.clk_sys(clk_sys), .rst_n(rst_n), .ahb_in(ahb_in), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pf_req(pf_req), .cmd_error(cmd_error));
  pfcd_sw_model u_pfcd_sw_model (.clk_sys(clk_sys), .hreadyout(hreadyout), .hrdata(hrdata), .ahb_o(ahb_in));
  always @(posedge clk_sys) begin
    if (pf_req.cfg_valid) begin
      n_cfg++;
      n_ctx += pf_req.ctx_valid;
      n_af += pf_req.af_set;
      sec = pf_req.secure;
      tg = {pf_req.substream_valid_flag, pf_req.ssid, pf_req.sid};
      a0 = pf_req.addr;
    end
    if (pf_req.tr_valid) begin
      n_tr++;
      a1 = pf_req.addr;
    end
  end
  task automatic test_done();
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_pfcd_sw_model.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    u_pfcd_sw_model.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic run(input pfcd_row_s r, input logic clr);
    logic [63:0] b;
    int          i;
    b = {32'h0, r.c2[31:12], 12'h000};
    wr(`PFCD_A_CTRL, r.ctl);
    wr(`PFCD_A_WIDTHS, r.wid);
    wr(`PFCD_A_CMD0, r.c0);
    wr(`PFCD_A_CMD1, r.c1);
    wr(`PFCD_A_CMD2, r.c2);
    wr(`PFCD_A_CMD3, 32'h0);
    rd(`PFCD_A_CONS, c0);
    {n_cfg, n_ctx, n_af, n_tr} = '0;
    wr(`PFCD_A_SUBMIT, {31'h0, r.sub});
    i = 0;
    do begin
      rd(`PFCD_A_STATUS, s);
      i++;
    end while (s[0] !== 1'b0 && i < 64);
    if (s[0] !== 1'b0) begin
      bad_count++;
      test_done();
    end
    rd(`PFCD_A_CONS, c1);
    chk("error", r.f[0], s[1]);
    chk("ignored", r.f[1], s[2]);
    chk("cons", c0 + {31'h0, !r.f[0]}, c1);
    chk("cfg", !(r.f[0] | r.f[1]), n_cfg);
    chk("ctx", r.f[2], n_ctx);
    chk("af", r.f[3], n_af);
    chk("tr", r.tr, n_tr);
    if (r.f[0]) chk("code", 64'h1, s[4:3]);
    if (r.f[1:0] == 2'h0) chk("secure", r.f[4], sec);
    if (r.f[1:0] == 2'h0) chk("tag", {r.f[2], r.f[2] ? r.c0[31:12] : 20'h0, r.c1}, tg);
    chk("cmd_error", r.f[0], cmd_error);
    if (r.tr > 0) chk("base", b, a0);
    if (r.tr > 0) chk("last", b + (64'(r.tr - 1) << 12), a1);
    if (clr) wr(`PFCD_A_STATUS, 32'h6);
  endtask : run
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`PFCD_A_CTRL, s);
    chk("ctrl_rst", 32'h0000_ffc0, s);
    chk("hresp", 1'b0, hresp);
    rd(`PFCD_A_WIDTHS, s);
    chk("wid_rst", 32'h0, s);
    wr(8'h24, 32'hffff_ffff);
    rd(8'h24, s);
    chk("unmapped", 32'h0, s);
    for (int k = 0; k < 15; k++) begin
      run(rows[k], 1'b1);
    end
    // Error left standing must block the next submit
    run(rows[5], 1'b0);
    run('{cc, ww, 32'h01, 32'h05, 32'h0, 1'b0, 0, 5'h01}, 1'b1);
    wr(`PFCD_A_CTRL, cc);
    wr(`PFCD_A_CMD0, 32'h02);
    wr(`PFCD_A_CMD2, 32'h1234_5004);
    wr(`PFCD_A_SUBMIT, 32'h0);
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("rst_tr", 1'b0, pf_req.tr_valid);
    chk("rst_rdy", 1'b0, hreadyout);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`PFCD_A_CONS, s);
    chk("rst_cons", 32'h0, s);
    test_done();
  end
endmodule : prefetch_command_decode_test
